// ---- rtl/psc_pkg.sv ----
// Shared constants and burst ordering for the pipelined SRAM pin control
package psc_pkg;

  localparam int ADDR_W_DEF = 18;
  localparam int LANES_DEF = 4;
  localparam int LANE_W_DEF = 8;
  localparam int BURST_W = 2;

  localparam logic MODE_INTERLEAVED = 1'h1;
  localparam logic MODE_LINEAR = 1'h0;
  localparam logic MODE_RST = MODE_INTERLEAVED;
  localparam logic OE_N_RST = 1'h1;
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;

  // Burst word address from start offset, beat count and order strap
  function automatic logic [BURST_W-1:0] psc_burst_addr(
    input logic [BURST_W-1:0] base,
    input logic [BURST_W-1:0] cnt,
    input logic               mode
  );
    logic [BURST_W-1:0] res;
    if (mode == MODE_INTERLEAVED) begin
      res = base ^ cnt;
    end else begin
      res = base + cnt;
    end
    return res;
  endfunction

endpackage

// ---- rtl/psc_lane_mem.sv ----
// Byte-lane storage array with per-lane write gating
`timescale 1ns/10ps
`default_nettype none

module psc_lane_mem
  import psc_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF,
  parameter int LANE_W = LANE_W_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [ADDR_W-1:0]       wr_addr,
  input  wire logic [LANES-1:0]        wr_lane,
  input  wire logic [LANES*LANE_W-1:0] wr_data,
  input  wire logic [LANES-1:0]        wr_par,
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output logic      [LANES*LANE_W-1:0] rd_data,
  output logic      [LANES-1:0]        rd_par
);

  localparam int DEPTH = 1 << ADDR_W;

  // One array per lane so a lane write never touches its neighbours
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
      if (wr_en && wr_lane[g]) begin
        mem[wr_addr] <= {wr_par[g], wr_data[g*LANE_W +: LANE_W]};
      end
    end

    assign rd_data[g*LANE_W +: LANE_W] = mem[rd_addr][LANE_W-1:0];
    assign rd_par[g] = mem[rd_addr][LANE_W];
  end

endmodule

`default_nettype wire

// ---- rtl/psc_sram.sv ----
// Pin-level control of a pipelined burst SRAM: select, burst, write, drive
`timescale 1ns/10ps
`default_nettype none

module psc_sram
  import psc_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF,
  parameter int LANE_W = LANE_W_DEF
) (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic [ADDR_W-1:0]       ADDR,
  input  wire logic                    CHIP_SELECT_LOW_FIRST_N,
  input  wire logic                    CHIP_SELECT_HIGH_SECOND,
  input  wire logic                    CHIP_SELECT_LOW_THIRD_N,
  input  wire logic                    WRITE_EN_N,
  input  wire logic [LANES-1:0]        BYTE_LANE_WRITE_SEL_N,
  input  wire logic                    ADVANCE_OR_LOAD,
  input  wire logic                    CLOCK_QUALIFY_N,
  input  wire logic                    OUTPUT_EN_N,
  input  wire logic                    BURST_ORDER_SEL,
  input  wire logic [LANES*LANE_W-1:0] DATA_LANES_IN,
  input  wire logic [LANES-1:0]        PARITY_LANES_IN,
  output logic      [LANES*LANE_W-1:0] DATA_LANES_OUT,
  output logic      [LANES-1:0]        PARITY_LANES_OUT,
  output logic                         DATA_OE_N
);

  localparam int DW = LANES * LANE_W;

  if (ADDR_W <= BURST_W || LANES < 1 || LANES > 4 || LANE_W < 1) begin : g_bad
    $error("psc_sram: unsupported address, lane count or lane width");
  end

  typedef struct packed {
    logic                 s1_act;
    logic                 s1_wr;
    logic [ADDR_W-1:0]    s1_addr;
    logic [LANES-1:0]     s1_lane;
    logic [BURST_W-1:0]   base;
    logic [BURST_W-1:0]   cnt;
    logic                 s2_wr;
    logic [ADDR_W-1:0]    s2_addr;
    logic [LANES-1:0]     s2_lane;
    logic                 drive;
    logic [DW-1:0]        dout;
    logic [LANES-1:0]     pout;
    logic                 oe_n;
    logic                 mode;
    logic                 mode_ok;
  } psc_state_t;

  psc_state_t st_r;
  psc_state_t st_nxt;

  logic              qual;
  logic              sel_in;
  logic              mem_wr;
  logic [DW-1:0]     mem_data;
  logic [LANES-1:0]  mem_par;
  logic [DW-1:0]     rd_word;
  logic [LANES-1:0]  rd_parw;
  logic              hit;

  // Masked edges are simply not acted on; all state holds except oe_n and the first strap capture
  assign qual = ~CLOCK_QUALIFY_N;

  assign sel_in = ~CHIP_SELECT_LOW_FIRST_N
                & CHIP_SELECT_HIGH_SECOND
                & ~CHIP_SELECT_LOW_THIRD_N;

  // Write data is sampled in the same slot that read data would be driven in
  assign mem_wr = qual & st_r.s2_wr;

  psc_lane_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .clk     (CLK),
    .wr_en   (mem_wr),
    .wr_addr (st_r.s2_addr),
    .wr_lane (st_r.s2_lane),
    .wr_data (DATA_LANES_IN),
    .wr_par  (PARITY_LANES_IN),
    .rd_addr (st_r.s1_addr),
    .rd_data (mem_data),
    .rd_par  (mem_par)
  );

  // Forward a write still in flight so a following read sees it
  assign hit = st_r.s2_wr & (st_r.s2_addr == st_r.s1_addr);

  for (genvar g = 0; g < LANES; g++) begin : g_fwd
    always_comb begin
      if (hit && st_r.s2_lane[g]) begin
        rd_word[g*LANE_W +: LANE_W] = DATA_LANES_IN[g*LANE_W +: LANE_W];
        rd_parw[g] = PARITY_LANES_IN[g];
      end else begin
        rd_word[g*LANE_W +: LANE_W] = mem_data[g*LANE_W +: LANE_W];
        rd_parw[g] = mem_par[g];
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    // Strap caught once after reset release, then frozen
    if (!st_r.mode_ok) begin
      st_nxt.mode = BURST_ORDER_SEL;
      st_nxt.mode_ok = 1'h1;
    end
    if (qual) begin
      // Stage two carries only writes; reads finish in stage one
      st_nxt.s2_wr = st_r.s1_act & st_r.s1_wr;
      st_nxt.s2_addr = st_r.s1_addr;
      st_nxt.s2_lane = st_r.s1_lane;
      // Deselect or write leaves the next slot undriven
      st_nxt.drive = st_r.s1_act & ~st_r.s1_wr;
      if (st_nxt.drive) begin
        st_nxt.dout = rd_word;
        st_nxt.pout = rd_parw;
      end
      if (!ADVANCE_OR_LOAD) begin
        st_nxt.s1_act = sel_in;
        st_nxt.s1_wr = ~WRITE_EN_N;
        st_nxt.s1_addr = ADDR;
        st_nxt.base = ADDR[BURST_W-1:0];
        st_nxt.cnt = CNT_RST;
      end else if (st_r.s1_act) begin
        st_nxt.cnt = st_r.cnt + CNT_STEP;
        st_nxt.s1_addr[BURST_W-1:0] =
          psc_burst_addr(st_r.base, st_nxt.cnt, st_r.mode);
      end
      // Advance while deselected cannot restart; a load is needed
      if (st_nxt.s1_act && st_nxt.s1_wr) begin
        st_nxt.s1_lane = ~BYTE_LANE_WRITE_SEL_N;
      end else begin
        st_nxt.s1_lane = '0;
      end
    end
    // Enable is sampled every edge, masked or not, as it has no qualify
    st_nxt.oe_n = ~(st_nxt.drive & ~OUTPUT_EN_N);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
      st_r.oe_n <= OE_N_RST;
      st_r.mode <= MODE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DATA_LANES_OUT = st_r.dout;
  assign PARITY_LANES_OUT = st_r.pout;
  assign DATA_OE_N = st_r.oe_n;

  sequence s_load_sel;
    qual && !ADVANCE_OR_LOAD && sel_in;
  endsequence

  sequence s_rd_cmd;
    s_load_sel and WRITE_EN_N;
  endsequence

  sequence s_rd_issue;
    qual && !OUTPUT_EN_N;
  endsequence

  chk_addr_capture: assert property (
    @(posedge CLK) disable iff (RST)
    s_load_sel |=> (st_r.s1_addr == $past(ADDR)) && st_r.s1_act
  ) else $error("address not captured on load");

  chk_lane_gate: assert property (
    @(posedge CLK) disable iff (RST)
    (s_load_sel and !WRITE_EN_N)
      |=> st_r.s1_lane == ~$past(BYTE_LANE_WRITE_SEL_N)
  ) else $error("write lanes do not follow lane selects");

  chk_read_no_lane: assert property (
    @(posedge CLK) disable iff (RST)
    s_rd_cmd |=> !st_r.s1_wr && (st_r.s1_lane == '0)
  ) else $error("read load marked as write");

  chk_burst_step: assert property (
    @(posedge CLK) disable iff (RST)
    (qual && ADVANCE_OR_LOAD && st_r.s1_act)
      |=> (st_r.cnt == $past(st_r.cnt) + CNT_STEP)
       && (st_r.s1_addr[ADDR_W-1:BURST_W]
           == $past(st_r.s1_addr[ADDR_W-1:BURST_W]))
  ) else $error("burst counter did not step");

  chk_load_reset_cnt: assert property (
    @(posedge CLK) disable iff (RST)
    (qual && !ADVANCE_OR_LOAD)
      |=> (st_r.cnt == CNT_RST) && (st_r.base == $past(ADDR[BURST_W-1:0]))
  ) else $error("load did not restart burst");

  chk_clk_mask: assert property (
    @(posedge CLK) disable iff (RST)
    CLOCK_QUALIFY_N |=> $stable(st_r.s1_act) && $stable(st_r.s1_addr)
      && $stable(st_r.drive) && $stable(st_r.dout) && $stable(st_r.s2_wr)
  ) else $error("state moved on a masked edge");

  chk_deselect: assert property (
    @(posedge CLK) disable iff (RST)
    // A masked edge after the deselect stretches the earlier read slot
    (qual && !ADVANCE_OR_LOAD && !sel_in)
      |=> !st_r.s1_act ##1 (st_r.oe_n || !$past(qual))
  ) else $error("deselect not honoured");

  chk_drive_oe: assert property (
    @(posedge CLK) disable iff (RST)
    !DATA_OE_N |-> $past(!OUTPUT_EN_N) && st_r.drive
  ) else $error("data driven without output enable");

  chk_oe_high: assert property (
    @(posedge CLK) disable iff (RST)
    OUTPUT_EN_N |=> DATA_OE_N
  ) else $error("pins driven while output enable high");

  chk_write_hiz: assert property (
    @(posedge CLK) disable iff (RST)
    (qual && st_r.s1_act && st_r.s1_wr) |=> DATA_OE_N [*1] ##1 1'h1
  ) else $error("pins driven in write data slot");

  chk_read_latency: assert property (
    @(posedge CLK) disable iff (RST)
    s_rd_cmd ##1 s_rd_issue
      |=> !DATA_OE_N && (DATA_LANES_OUT == $past(rd_word))
  ) else $error("read data late or wrong");

  chk_mode_fixed: assert property (
    @(posedge CLK) disable iff (RST)
    st_r.mode_ok |=> $stable(st_r.mode) && st_r.mode_ok
  ) else $error("burst order changed in operation");

endmodule

`default_nettype wire

// ---- tb/psc_master_model.sv ----
// Bus master model driving the SRAM pins and the shared data wire
`timescale 1ns/10ps
`default_nettype none

module psc_master_model (
  input  wire logic        clk,
  output var logic  [5:0]  addr,
  output var logic         cs1_n,
  output var logic         cs2,
  output var logic         cs3_n,
  output var logic         we_n,
  output var logic  [3:0]  bw_n,
  output var logic         adv,
  output var logic         cen_n,
  output var logic         oe_n,
  input  wire logic [31:0] dout,
  input  wire logic [3:0]  pout,
  input  wire logic        doe_n,
  output logic      [31:0] din,
  output logic      [3:0]  par_in
);
  logic [35:0] drv = 36'h0, s1 = 36'h0, s2 = 36'h0, last = 36'h0;
  logic        v1 = 1'b0, v2 = 1'b0, vd = 1'b0, act = 1'b0, wr = 1'b0;

  initial begin
    {oe_n, cs1_n, cs2, cs3_n, we_n, bw_n, adv, cen_n} = 11'h37C;
    addr = 6'h0;
  end

  // Released wire shows the inverse of its last level, not a stale copy
  assign {par_in, din} = !doe_n ? {pout, dout} : vd ? drv : ~last;
  always @(posedge clk) last <= {par_in, din};

  // Write data goes out two qualified cycles after its command
  task automatic cyc(input logic [10:0] c, input logic [5:0] a,
                     input logic [35:0] w);
    @(posedge clk);
    {oe_n, cs1_n, cs2, cs3_n, we_n, bw_n, adv, cen_n} <= c;
    addr <= a;
    if (!c[0]) begin
      if (!c[1]) begin
        act = (c[9:7] == 3'h2);
        wr  = !c[6];
      end
      {drv, vd} <= {s2, v2};
      {s2, v2}  <= {s1, v1};
      {s1, v1}  <= {w, act & wr};
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/test_psc_sram.sv ----
// Self-checking bench for the pipelined SRAM pin control
`timescale 1ns/10ps
`default_nettype none

module test_psc_sram;
  localparam logic [10:0] DS = 11'h37C, RD = 11'h17C, WR = 11'h100;
  localparam logic [10:0] WP = 11'h128, AD = 11'h17E, MW = 11'h101;
  localparam logic [10:0] MK = 11'h37D, DO = 11'h77C;
  localparam logic [1:0]  NO = 2'h2;
  localparam logic [35:0] Z = 36'h0, A0 = 36'hF_A5A5_A5A5;
  localparam logic [35:0] B0 = 36'h5_0F0F_1234, C0 = 36'h0_3C3C_3C3C;
  localparam logic [35:0] M8 = 36'hA_A53C_A53C;
  logic CLK = 1'b0, RST = 1'b1, order_sel = 1'b1;
  int   mismatches = 0, num_checks = 0, cycles = 0;
  wire [5:0]  addr;
  wire        cs1_n, cs2, cs3_n, we_n, adv, cen_n, oe_n, doe_n;
  wire [3:0]  bw_n, pout, par_in;
  wire [31:0] dout, din;

  psc_master_model m (
    .clk(CLK), .addr(addr), .cs1_n(cs1_n), .cs2(cs2), .cs3_n(cs3_n),
    .we_n(we_n), .bw_n(bw_n), .adv(adv), .cen_n(cen_n), .oe_n(oe_n),
    .dout(dout), .pout(pout), .doe_n(doe_n), .din(din), .par_in(par_in)
  );
  psc_sram #(.ADDR_W(6)) dut (
    .CLK(CLK), .RST(RST), .ADDR(addr),
    .CHIP_SELECT_LOW_FIRST_N(cs1_n), .CHIP_SELECT_HIGH_SECOND(cs2),
    .CHIP_SELECT_LOW_THIRD_N(cs3_n), .WRITE_EN_N(we_n),
    .BYTE_LANE_WRITE_SEL_N(bw_n), .ADVANCE_OR_LOAD(adv),
    .CLOCK_QUALIFY_N(cen_n), .OUTPUT_EN_N(oe_n),
    .BURST_ORDER_SEL(order_sel), .DATA_LANES_IN(din),
    .PARITY_LANES_IN(par_in), .DATA_LANES_OUT(dout),
    .PARITY_LANES_OUT(pout), .DATA_OE_N(doe_n)
  );

  always #2.5 CLK = ~CLK;
  // Run needs under a hundred cycles; far more means a hang
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle, then judge the drive slot it lands on
  task automatic op(input logic [10:0] c, input logic [5:0] a,
                    input logic [35:0] w, input logic [1:0] eoe,
                    input logic [35:0] ed);
    m.cyc(c, a, w);
    #1;
    if (eoe != NO) chk({35'h0, doe_n}, {35'h0, eoe[0]});
    if (eoe == 2'h0) chk({pout, dout}, ed);
  endtask

  task automatic reset(input logic strap);
    RST <= 1'b1;
    order_sel <= strap;
    repeat (16) @(posedge CLK);
    chk({35'h0, doe_n}, 36'h1);
    RST <= 1'b0;
  endtask

  task automatic t_lanes();
    op(WR, 6'h08, A0, NO, Z);
    op(WR, 6'h09, B0, 2'h1, Z);
    op(WP, 6'h08, C0, 2'h1, Z);
    op(RD, 6'h08, Z, 2'h1, Z);
    op(RD, 6'h09, Z, 2'h1, Z);
    op(DS, 6'h0, Z, 2'h0, M8);
    op(DS, 6'h0, Z, 2'h0, B0);
    op(DS, 6'h0, Z, 2'h1, Z);
  endtask

  // Masked edges must neither write nor end the pending read
  task automatic t_freeze();
    op(RD, 6'h08, Z, NO, Z);
    op(MW, 6'h09, C0, NO, Z);
    op(MK, 6'h0, Z, NO, Z);
    op(RD, 6'h09, Z, NO, Z);
    op(DS, 6'h0, Z, 2'h0, M8);
    op(DS, 6'h0, Z, 2'h0, B0);
  endtask

  task automatic t_burst(input logic il);
    logic [35:0] d[4];
    int          b;
    for (int n = 0; n < 4; n++) begin
      d[n] = {4'(n), 32'h7700_0000 + 32'(n)};
      op(WR, 6'(16 + n), d[n], NO, Z);
    end
    op(DS, 6'h0, Z, NO, Z);
    op(RD, 6'h11, Z, NO, Z);
    for (int k = 0; k < 5; k++) begin
      b = (k + 3) % 4;
      op(k < 3 ? AD : DS, 6'h0, Z, k ? 2'h0 : NO,
         d[il ? 1 ^ b : (1 + b) % 4]);
    end
  endtask

  task automatic t_sel();
    logic [2:0] cs[4] = '{3'h2, 3'h6, 3'h0, 3'h3};
    for (int k = 0; k < 4; k++) begin
      op({1'b0, cs[k], RD[6:0]}, 6'h09, Z, NO, Z);
      op(DS, 6'h0, Z, NO, Z);
      op(DS, 6'h0, Z, {1'b0, k != 0}, B0);
    end
    op(RD, 6'h09, Z, NO, Z);
    op(DO, 6'h0, Z, NO, Z);
    op(DS, 6'h0, Z, 2'h1, Z);
    op(AD, 6'h0, Z, NO, Z);
    op(DS, 6'h0, Z, NO, Z);
    op(DS, 6'h0, Z, 2'h1, Z);
  endtask

  initial begin
    reset(1'b1);
    t_lanes();
    t_freeze();
    t_burst(1'b1);
    reset(1'b0);
    t_burst(1'b0);
    t_sel();
    results();
  end
endmodule
`default_nettype wire
